// *** design/tcb_pkg.sv ***
// constants, register map and command codes for the timer control b block
// assumes a 32-bit apb slave on a single pclk domain
package tcb_pkg;

	localparam int CNT_W = 16;
	localparam int NUM_CC = 2;
	localparam int PSC_W = 3;
	localparam int DIV_W = 8;

	// register byte offsets
	localparam logic [7:0] OFF_SET_VIEW = 8'h00;
	localparam logic [7:0] OFF_CLR_VIEW = 8'h04;
	localparam logic [7:0] OFF_CONTROL = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_CYC_VAL = 8'h10;
	localparam logic [7:0] OFF_CYC_BUF = 8'h14;
	localparam logic [7:0] OFF_CC_BUF0 = 8'h18;
	localparam logic [7:0] OFF_CC_VAL0 = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h28;

	// control b fields
	localparam int CB_DIR = 0;
	localparam int CB_BUFFER_UPDATE_LOCK = 1;
	localparam int CB_SINGLE_RUN_BIT = 2;
	localparam int CB_CMD_LO = 5;
	localparam int CB_CMD_HI = 7;

	// control register fields
	localparam int CT_ENABLE = 0;
	localparam int CT_CAPTURE = 1;
	localparam int CT_PSC_LO = 4;
	localparam int CT_PSC_HI = 6;

	// status fields
	localparam int ST_STOPPED = 0;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_RETRIGGER = 3'h1,
		CMD_STOP = 3'h2,
		CMD_UPDATE = 3'h3
	} tcb_cmd_t;

	localparam logic [2:0] CMD_ZERO = 3'h0;
	localparam logic [7:0] TIMER_CONTROL_B_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [CNT_W-1:0] CYC_RESET = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CC_RESET = 16'h0000;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;

endpackage

// *** design/tcb_tick_if.sv ***
// carries prescaler setup and the prescaled tick between timer and prescaler
// assumes both ends run on pclk
`timescale 1ns/100ps
`default_nettype none
interface tcb_tick_if;
	logic                      run;
	logic [tcb_pkg::PSC_W-1:0] sel;
	logic                      tick;

	modport timer (output run, output sel, input tick);
	modport presc (input run, input sel, output tick);
endinterface
`default_nettype wire

// *** design/tcb_prescaler.sv ***
// prescaler: one-cycle tick every 2**sel pclk cycles while run is high
// assumes sel changes only while the timer is idle, otherwise one period may be short
`timescale 1ns/100ps
`default_nettype none
module tcb_prescaler
(
	// clock and reset
	input  wire logic     pclk,
	input  wire logic     presetn,
	// link to timer
	tcb_tick_if.presc     tk
);
	logic [tcb_pkg::DIV_W-1:0] div_ff;
	logic [tcb_pkg::DIV_W-1:0] nxt_div;
	logic                      tick_ff;
	logic                      nxt_tick;
	logic [tcb_pkg::DIV_W-1:0] limit;

	always_comb
	begin
		limit = (tcb_pkg::DIV_ONE << tk.sel) - tcb_pkg::DIV_ONE;
		nxt_div = div_ff;
		nxt_tick = 1'b0;
		if (!tk.run)
		begin
			nxt_div = tcb_pkg::DIV_ZERO;
		end
		else if (div_ff >= limit)
		begin
			nxt_div = tcb_pkg::DIV_ZERO;
			nxt_tick = 1'b1;
		end
		else
		begin
			nxt_div = div_ff + tcb_pkg::DIV_ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_ff <= tcb_pkg::DIV_ZERO;
			tick_ff <= 1'b0;
		end
		else
		begin
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end

	assign tk.tick = tick_ff;
endmodule
`default_nettype wire

// *** design/tcb_timer.sv ***
// timer/counter with set and clear views of control b, apb slave
// assumes an apb3 master on pclk; capture_in is asynchronous
//
// Summary of operation
// - clear view at 0x04 clears control bits by writing ones, no read-modify-write.
// - set and clear views read back one shared control b register.
// - a command in bits 7:5 runs on the next prescaled tick.
// - the command field reads zero once the command has run.
// - writing zero to the command field through the clear view changes nothing.
// - writing a one to any command bit through the clear view cancels it.
// - zero written to single-run, lock or direction through clear view has no effect.
// - a one written to bit 2 through the clear view disables single-run.
// - single-run off wraps and continues; on wraps then stops.
// - lock set blocks buffer-to-active copy on hardware update; clear allows it.
// - the lock has no effect while input capture is enabled.
// - a one written to the lock through the clear view clears the lock.
// - bit 0 selects the counting direction.
`timescale 1ns/100ps
`default_nettype none
module tcb_timer
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// timer pins
	input  wire logic        capture_in,
	output logic [1:0]       wave_out,
	output logic             update_out
);
	localparam int NC = tcb_pkg::NUM_CC;
	localparam int CW = tcb_pkg::CNT_W;

	tcb_tick_if tk();

	tcb_prescaler u_presc
	(
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (tk)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// apb front end: answer in the first access cycle, data registered in setup
	logic          rdy_ff, nxt_rdy;
	logic          err_ff, nxt_err;
	logic [31:0]   rdata_ff, nxt_rdata;
	logic          wr_en;
	logic          mapped;

	// control state
	logic [7:0]    timer_control_b_ff, nxt_timer_control_b;
	logic [7:0]    control_ff, nxt_control;
	logic [CW-1:0] count_ff, nxt_count;
	logic [CW-1:0] cyc_ff, nxt_cyc;
	logic [CW-1:0] cyc_buf_ff, nxt_cyc_buf;
	logic [CW-1:0] cc_ff [NC];
	logic [CW-1:0] nxt_cc [NC];
	logic [CW-1:0] cc_buf_ff [NC];
	logic [CW-1:0] nxt_cc_buf [NC];
	logic          stopped_ff, nxt_stopped;
	logic [1:0]    wave_ff, nxt_wave;
	logic          upd_ff, nxt_upd;

	// capture input synchroniser
	logic          cap_s1_ff, cap_s2_ff, cap_s3_ff, cap_lvl_ff, nxt_cap_lvl;
	logic          cap_edge;

	logic [2:0]    cmd;
	logic          wrap;
	logic          hw_update;

	assign wr_en = psel && penable && pwrite && rdy_ff && !err_ff;
	assign cmd = timer_control_b_ff[tcb_pkg::CB_CMD_HI:tcb_pkg::CB_CMD_LO];
	assign tk.run = control_ff[tcb_pkg::CT_ENABLE];
	assign tk.sel = control_ff[tcb_pkg::CT_PSC_HI:tcb_pkg::CT_PSC_LO];

	always_comb
	begin
		mapped = 1'b0;
		if (hit(paddr, tcb_pkg::OFF_SET_VIEW) || hit(paddr, tcb_pkg::OFF_CLR_VIEW) ||
			hit(paddr, tcb_pkg::OFF_CONTROL) || hit(paddr, tcb_pkg::OFF_COUNT) ||
			hit(paddr, tcb_pkg::OFF_CYC_VAL) || hit(paddr, tcb_pkg::OFF_CYC_BUF) ||
			hit(paddr, tcb_pkg::OFF_STATUS))
		begin
			mapped = 1'b1;
		end
		for (int i = 0; i < NC; i++)
		begin
			if (hit(paddr, tcb_pkg::OFF_CC_BUF0 + 8'(4 * i)) ||
				hit(paddr, tcb_pkg::OFF_CC_VAL0 + 8'(4 * i)))
			begin
				mapped = 1'b1;
			end
		end
	end

	always_comb
	begin
		nxt_rdy = 1'b0;
		nxt_err = 1'b0;
		nxt_rdata = rdata_ff;
		if (psel && !penable)
		begin
			nxt_rdy = 1'b1;
			nxt_err = !mapped;
			nxt_rdata = 32'h0000_0000;
			// both views show the one register; bits 4:3 are never stored
			if (hit(paddr, tcb_pkg::OFF_SET_VIEW) || hit(paddr, tcb_pkg::OFF_CLR_VIEW))
				nxt_rdata[7:0] = timer_control_b_ff;
			if (hit(paddr, tcb_pkg::OFF_CONTROL))
				nxt_rdata[7:0] = control_ff;
			if (hit(paddr, tcb_pkg::OFF_COUNT))
				nxt_rdata[CW-1:0] = count_ff;
			if (hit(paddr, tcb_pkg::OFF_CYC_VAL))
				nxt_rdata[CW-1:0] = cyc_ff;
			if (hit(paddr, tcb_pkg::OFF_CYC_BUF))
				nxt_rdata[CW-1:0] = cyc_buf_ff;
			if (hit(paddr, tcb_pkg::OFF_STATUS))
				nxt_rdata[tcb_pkg::ST_STOPPED] = stopped_ff;
			for (int i = 0; i < NC; i++)
			begin
				if (hit(paddr, tcb_pkg::OFF_CC_BUF0 + 8'(4 * i)))
					nxt_rdata[CW-1:0] = cc_buf_ff[i];
				if (hit(paddr, tcb_pkg::OFF_CC_VAL0 + 8'(4 * i)))
					nxt_rdata[CW-1:0] = cc_ff[i];
			end
		end
	end

	// control b: execution clears the command, a write in the same cycle wins
	always_comb
	begin
		nxt_timer_control_b = timer_control_b_ff;
		nxt_control = control_ff;
		if (tk.tick && (cmd != tcb_pkg::CMD_ZERO))
			nxt_timer_control_b[tcb_pkg::CB_CMD_HI:tcb_pkg::CB_CMD_LO] = tcb_pkg::CMD_ZERO;
		if (wr_en && hit(paddr, tcb_pkg::OFF_SET_VIEW))
		begin
			nxt_timer_control_b[2:0] = timer_control_b_ff[2:0] | pwdata[2:0];
			if (pwdata[tcb_pkg::CB_CMD_HI:tcb_pkg::CB_CMD_LO] != tcb_pkg::CMD_ZERO)
				nxt_timer_control_b[tcb_pkg::CB_CMD_HI:tcb_pkg::CB_CMD_LO] =
					pwdata[tcb_pkg::CB_CMD_HI:tcb_pkg::CB_CMD_LO];
		end
		if (wr_en && hit(paddr, tcb_pkg::OFF_CLR_VIEW))
		begin
			// ones clear, zeros leave the stored bit alone
			nxt_timer_control_b[tcb_pkg::CB_SINGLE_RUN_BIT] = timer_control_b_ff[tcb_pkg::CB_SINGLE_RUN_BIT] &
				!pwdata[tcb_pkg::CB_SINGLE_RUN_BIT];
			nxt_timer_control_b[tcb_pkg::CB_BUFFER_UPDATE_LOCK] = timer_control_b_ff[tcb_pkg::CB_BUFFER_UPDATE_LOCK] &
				!pwdata[tcb_pkg::CB_BUFFER_UPDATE_LOCK];
			nxt_timer_control_b[tcb_pkg::CB_DIR] = timer_control_b_ff[tcb_pkg::CB_DIR] &
				!pwdata[tcb_pkg::CB_DIR];
			if (pwdata[tcb_pkg::CB_CMD_HI:tcb_pkg::CB_CMD_LO] != tcb_pkg::CMD_ZERO)
				nxt_timer_control_b[tcb_pkg::CB_CMD_HI:tcb_pkg::CB_CMD_LO] = tcb_pkg::CMD_ZERO;
		end
		nxt_timer_control_b[4:3] = 2'h0;
		if (wr_en && hit(paddr, tcb_pkg::OFF_CONTROL))
		begin
			nxt_control = 8'h00;
			nxt_control[tcb_pkg::CT_ENABLE] = pwdata[tcb_pkg::CT_ENABLE];
			nxt_control[tcb_pkg::CT_CAPTURE] = pwdata[tcb_pkg::CT_CAPTURE];
			nxt_control[tcb_pkg::CT_PSC_HI:tcb_pkg::CT_PSC_LO] =
				pwdata[tcb_pkg::CT_PSC_HI:tcb_pkg::CT_PSC_LO];
		end
	end

	assign cap_edge = nxt_cap_lvl && !cap_lvl_ff;

	always_comb
	begin
		nxt_cap_lvl = cap_lvl_ff;
		if (cap_s2_ff == cap_s3_ff)
			nxt_cap_lvl = cap_s3_ff;
	end

	// counter: wrap is the hardware update condition
	always_comb
	begin
		nxt_count = count_ff;
		nxt_cyc = cyc_ff;
		nxt_cyc_buf = cyc_buf_ff;
		nxt_stopped = stopped_ff;
		nxt_upd = 1'b0;
		nxt_wave = wave_ff;
		hw_update = 1'b0;
		wrap = timer_control_b_ff[tcb_pkg::CB_DIR] ? (count_ff == tcb_pkg::CNT_RESET) :
			(count_ff >= cyc_ff);
		for (int i = 0; i < NC; i++)
		begin
			nxt_cc[i] = cc_ff[i];
			nxt_cc_buf[i] = cc_buf_ff[i];
		end
		if (wr_en && hit(paddr, tcb_pkg::OFF_CYC_BUF))
			nxt_cyc_buf = pwdata[CW-1:0];
		for (int i = 0; i < NC; i++)
		begin
			if (wr_en && hit(paddr, tcb_pkg::OFF_CC_BUF0 + 8'(4 * i)))
				nxt_cc_buf[i] = pwdata[CW-1:0];
		end
		if (tk.tick)
		begin
			unique case (tcb_pkg::tcb_cmd_t'(cmd))
				tcb_pkg::CMD_RETRIGGER:
				begin
					nxt_count = timer_control_b_ff[tcb_pkg::CB_DIR] ? cyc_ff : tcb_pkg::CNT_RESET;
					nxt_stopped = 1'b0;
				end
				tcb_pkg::CMD_STOP:
				begin
					nxt_stopped = 1'b1;
				end
				tcb_pkg::CMD_UPDATE:
				begin
					hw_update = 1'b1;
				end
				default:
				begin
					if (!stopped_ff)
					begin
						if (wrap)
						begin
							// lock only matters when compare values come from buffers
							hw_update = !timer_control_b_ff[tcb_pkg::CB_BUFFER_UPDATE_LOCK] ||
								control_ff[tcb_pkg::CT_CAPTURE];
							nxt_count = timer_control_b_ff[tcb_pkg::CB_DIR] ? cyc_ff :
								tcb_pkg::CNT_RESET;
							if (timer_control_b_ff[tcb_pkg::CB_SINGLE_RUN_BIT])
								nxt_stopped = 1'b1;
						end
						else if (timer_control_b_ff[tcb_pkg::CB_DIR])
							nxt_count = count_ff - CW'(1);
						else
							nxt_count = count_ff + CW'(1);
					end
				end
			endcase
		end
		if (hw_update)
		begin
			nxt_upd = 1'b1;
			nxt_cyc = cyc_buf_ff;
			// in capture mode compare values are never loaded from buffers; only cc_ff[0] takes captures
			if (!control_ff[tcb_pkg::CT_CAPTURE])
			begin
				for (int i = 0; i < NC; i++)
					nxt_cc[i] = cc_buf_ff[i];
			end
		end
		if (control_ff[tcb_pkg::CT_CAPTURE] && cap_edge)
			nxt_cc[0] = count_ff;
		for (int i = 0; i < NC; i++)
			nxt_wave[i] = !control_ff[tcb_pkg::CT_CAPTURE] && (count_ff < cc_ff[i]);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdy_ff <= 1'b0;
			err_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			timer_control_b_ff <= tcb_pkg::TIMER_CONTROL_B_RESET;
			control_ff <= tcb_pkg::CONTROL_RESET;
			count_ff <= tcb_pkg::CNT_RESET;
			cyc_ff <= tcb_pkg::CYC_RESET;
			cyc_buf_ff <= tcb_pkg::CYC_RESET;
			for (int i = 0; i < NC; i++)
			begin
				cc_ff[i] <= tcb_pkg::CC_RESET;
				cc_buf_ff[i] <= tcb_pkg::CC_RESET;
			end
			stopped_ff <= 1'b0;
			wave_ff <= 2'h0;
			upd_ff <= 1'b0;
			cap_s1_ff <= 1'b0;
			cap_s2_ff <= 1'b0;
			cap_s3_ff <= 1'b0;
			cap_lvl_ff <= 1'b0;
		end
		else
		begin
			rdy_ff <= nxt_rdy;
			err_ff <= nxt_err;
			rdata_ff <= nxt_rdata;
			timer_control_b_ff <= nxt_timer_control_b;
			control_ff <= nxt_control;
			count_ff <= nxt_count;
			cyc_ff <= nxt_cyc;
			cyc_buf_ff <= nxt_cyc_buf;
			for (int i = 0; i < NC; i++)
			begin
				cc_ff[i] <= nxt_cc[i];
				cc_buf_ff[i] <= nxt_cc_buf[i];
			end
			stopped_ff <= nxt_stopped;
			wave_ff <= nxt_wave;
			upd_ff <= nxt_upd;
			cap_s1_ff <= capture_in;
			cap_s2_ff <= cap_s1_ff;
			cap_s3_ff <= cap_s2_ff;
			cap_lvl_ff <= nxt_cap_lvl;
		end
	end

	assign prdata = rdata_ff;
	assign pready = rdy_ff;
	assign pslverr = err_ff;
	assign wave_out = wave_ff;
	assign update_out = upd_ff;
endmodule
`default_nettype wire

// *** testbench/tcb_timer_asserts.sv ***
// apb handshake and control b readback checks for tcb_timer
// assumes binding to tcb_timer on one pclk domain
`timescale 1ns/100ps
`default_nettype none
module tcb_timer_chk
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic vw;
	assign vw = paddr == tcb_pkg::OFF_CLR_VIEW || paddr == tcb_pkg::OFF_SET_VIEW;

	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans)
		else $error("no answer after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one)
		else $error("ready held too long");
	property p_cause; pready |-> $past(psel && !penable); endproperty
	a_cause: assert property (p_cause)
		else $error("ready without setup");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err)
		else $error("error without ready");
	property p_map; pready && vw |-> !pslverr; endproperty
	a_map: assert property (p_map)
		else $error("view access refused");
	property p_gap; pready && !pwrite && vw |-> prdata[31:8] == 24'h0 && prdata[4:3] == 2'h0;
	endproperty
	a_gap: assert property (p_gap)
		else $error("reserved bits not zero");
	property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved");
	property p_unm; pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_unm: assert property (p_unm)
		else $error("unmapped read not zero");
endmodule
bind tcb_timer tcb_timer_chk tcb_timer_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
`default_nettype wire

// *** testbench/test_timer_control_b_clear.sv ***
// self-checking bench for tcb_timer driven over apb
// assumes tcb_pkg compiled first; capture_in is left low
`timescale 1ns/100ps
`default_nettype none
module test_timer_control_b_clear;
	localparam logic [7:0] SV = tcb_pkg::OFF_SET_VIEW;
	localparam logic [7:0] CV = tcb_pkg::OFF_CLR_VIEW;
	localparam logic [7:0] CT = tcb_pkg::OFF_CONTROL;
	localparam logic [7:0] CNT = tcb_pkg::OFF_COUNT;
	localparam logic [7:0] CYV = tcb_pkg::OFF_CYC_VAL;
	localparam logic [7:0] CB = tcb_pkg::OFF_CYC_BUF;
	localparam logic [7:0] ST = tcb_pkg::OFF_STATUS;
	localparam logic [7:0] CCB = tcb_pkg::OFF_CC_BUF0;
	localparam logic [7:0] CCV = tcb_pkg::OFF_CC_VAL0;
	logic pclk, presetn, psel, penable, pwrite, capture_in, pready, pslverr, update_out;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] wave_out;
	int miscompares;
	int n_tests;
	int n_upd;
	logic [32:0] exp_q[$];

	tcb_timer tcb_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_in(capture_in), .wave_out(wave_out),
		.update_out(update_out));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic results();
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic fail(input string m);
		miscompares++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	// 4-state arguments so an unknown output never slips through
	task automatic cnt(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e)
			fail(m);
	endtask

	// one transfer plus an idle cycle, so strobes never move twice in a step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			fail("no ready");
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
		exp_q.push_back({err, e});
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// read checker: oldest note against each completed read
	always @(posedge pclk)
		if (pready === 1'b1 && pwrite === 1'b0)
		begin
			n_tests++;
			if (exp_q.size() == 0)
				fail("unexpected read");
			else if ({pslverr, prdata} !== exp_q.pop_front())
				fail("read mismatch");
		end

	// counts buffer copies as seen on the update pulse
	always @(posedge pclk)
		if (update_out === 1'b1)
			n_upd++;

	initial
	begin
		logic [2:0] s, c, m;
		logic [31:0] r;
		int u;
		{presetn, psel, penable, pwrite, capture_in} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		n_tests = 0;
		n_upd = 0;
		u = 0;
		m = 3'h0;
		r = $urandom(32'h8213);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CV, 32'h0, 1'b0);
		rd(CYV, 32'hffff, 1'b0);
		rd(8'h30, 32'h0, 1'b1);
		for (int i = 0; i < 12; i++)
		begin
			s = 3'($urandom);
			c = 3'($urandom);
			r = $urandom;
			wr(SV, {29'h0, s});
			m = m | s;
			wr(CV, {27'h0, r[1:0], c});
			m = m & ~c;
			rd(CV, {29'h0, m}, 1'b0);
			rd(SV, {29'h0, m}, 1'b0);
		end
		wr(CV, 32'h7);
		// timer stays disabled, so a command remains pending
		for (int i = 1; i < 8; i++)
		begin
			wr(SV, 32'(i) << 5);
			wr(CV, 32'h0);
			rd(CV, 32'(i) << 5, 1'b0);
			wr(CV, 32'h20 << (i % 3));
			rd(SV, 32'h0, 1'b0);
		end
		wr(CT, 32'h1);
		wr(SV, 32'h40);
		wt(3);
		rd(CV, 32'h0, 1'b0);
		rd(ST, 32'h1, 1'b0);
		wr(CB, 32'h8);
		wr(CCB, 32'h4);
		wr(SV, 32'h60);
		wt(3);
		rd(CYV, 32'h8, 1'b0);
		rd(CCV, 32'h4, 1'b0);
		cnt(n_upd, 32'h1, "no update pulse");
		wr(SV, 32'h20);
		wt(40);
		rd(ST, 32'h0, 1'b0);
		wr(SV, 32'h4);
		wt(40);
		rd(ST, 32'h1, 1'b0);
		rd(CNT, 32'h0, 1'b0);
		cnt({30'h0, wave_out}, 32'h1, "wave level at stop");
		wr(SV, 32'h1);
		wr(SV, 32'h20);
		wt(40);
		rd(CNT, 32'h8, 1'b0);
		cnt({30'h0, wave_out}, 32'h0, "wave level counting down");
		wr(CV, 32'h5);
		wr(SV, 32'h2);
		wr(CB, 32'h5);
		wr(CCB, 32'h6);
		u = n_upd;
		wr(SV, 32'h20);
		wt(40);
		rd(CYV, 32'h8, 1'b0);
		rd(CCV, 32'h4, 1'b0);
		cnt(n_upd, u, "update while locked");
		wr(CV, 32'h2);
		wt(40);
		rd(CYV, 32'h5, 1'b0);
		rd(CCV, 32'h6, 1'b0);
		n_tests++;
		if (n_upd <= u)
			fail("no update after unlock");
		wr(SV, 32'h2);
		wr(CB, 32'h9);
		wr(CT, 32'h3);
		wt(40);
		rd(CYV, 32'h9, 1'b0);
		cnt({30'h0, wave_out}, 32'h0, "wave in capture mode");
		results();
	end
endmodule
`default_nettype wire
